// [hw/irq_defines.svh]
// constants of the interrupt mask, vector and gpio trigger block
// assumes an 8-bit register port and one gpio port of up to eight pins
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define ADDR_PORT_DATA        8'h00
`define ADDR_PIN_IRQ_ENABLE   8'h01
`define ADDR_EDGE_SEL_LOW     8'h02
`define ADDR_EDGE_SEL_HIGH    8'h03
`define ADDR_GENERAL_MASK     8'he0
`define ADDR_BLOCK_MASK       8'he1
`define ADDR_IRQ_VECTOR       8'he2

// ****************************************************************
// reset values and fields
// ****************************************************************
`define RST_BYTE              8'h00
`define RST_SOURCES           15'h0000
`define GEN_SUPPLY_BIT        0
`define GEN_COL_LSB           1
`define GEN_COL_MSB           4
`define GEN_GPIO_BIT          5
`define GEN_SLEEP_BIT         6
`define GEN_WRITABLE          8'h7f

// ****************************************************************
// vectors and source slots (lower slot wins)
// ****************************************************************
`define VEC_BASE              8'h04
`define VEC_STEP              8'h04
`define VEC_NONE              8'h00
`define NUM_SOURCES           15
`define SLOT_SUPPLY           0
`define SLOT_BLOCK_LSB        1
`define SLOT_BLOCK_MSB        8
`define SLOT_COL_LSB          9
`define SLOT_COL_MSB          12
`define SLOT_GPIO             13
`define SLOT_SLEEP            14

`endif

// [hw/irq_pkg.sv]
// types shared by the interrupt block and its gpio trigger cells
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package irq_pkg;
    // trigger code formed as {edge_select_high, edge_select_low}
    typedef enum logic [1:0] {
        TRIG_NONE    = 2'h0,
        TRIG_RISING  = 2'h1,
        TRIG_FALLING = 2'h2,
        TRIG_CHANGE  = 2'h3
    } trig_mode_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;
endpackage
`default_nettype wire

// [hw/gpio_pin_trigger.sv]
// one gpio pin: trigger detection and its per-pin interrupt output
// assumes the pin level is synchronous to clk
`default_nettype none
module gpio_pin_trigger
    import irq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       pin,
    input  wire logic       enable,
    input  wire irq_pkg::trig_mode_e mode,
    input  wire logic       capture,
    output logic            irq_out
);
    logic prev;
    logic captured;
    logic latched;
    logic edge_hit;

    always_ff @(posedge clk) begin
        if (reset) begin
            prev <= 1'b0;
        end else begin
            prev <= pin;
        end
    end

    // level seen at the last port read [RULE10]
    always_ff @(posedge clk) begin
        if (reset) begin
            captured <= 1'b0;
        end else if (capture) begin
            captured <= pin;
        end
    end

    always_comb begin
        edge_hit = ((mode == TRIG_RISING) && pin && !prev) ||
                   ((mode == TRIG_FALLING) && !pin && prev); // [RULE9]
    end

    // edge latch cleared by a port read; a new edge wins over the clear
    always_ff @(posedge clk) begin
        if (reset) begin
            latched <= 1'b0;
        end else if (edge_hit) begin
            latched <= 1'b1;
        end else if (capture || mode == TRIG_NONE) begin
            latched <= 1'b0;
        end
    end

    always_comb begin
        case (mode)
            TRIG_CHANGE: irq_out = enable && (pin != captured); // [RULE10] [RULE7]
            TRIG_NONE:   irq_out = 1'b0;                        // [RULE11]
            default:     irq_out = enable && latched;           // [RULE7]
        endcase
    end
endmodule // gpio_pin_trigger
`default_nettype wire

// [hw/irq_priority_pick.sv]
// picks the lowest-numbered active request and forms its vector byte
// assumes slot 0 is the highest priority
`default_nettype none
`include "irq_defines.svh"
module irq_priority_pick #(
    parameter int N = `NUM_SOURCES
) (
    input  wire logic [N-1:0] req,
    output logic              valid,
    output logic [7:0]        vector
);
    initial begin
        if (N < 1 || N > 15) begin
            $error("irq_priority_pick: N must be 1..15");
        end
    end

    function automatic logic [3:0] lowest(input logic [N-1:0] r);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (r[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    always_comb begin
        valid  = |req;
        vector = `VEC_NONE;                                      // [RULE19]
        if (valid) begin
            vector = 8'(`VEC_BASE + {4'h0, lowest(req)} * `VEC_STEP); // [RULE18] [RULE20]
        end
    end
endmodule // irq_priority_pick
`default_nettype wire

// [hw/irq_mask_vector_gpio.sv]
// interrupt pending flops, masks, vector register and gpio aggregation
// assumes single clock, sources give one-cycle event pulses, port reads
// of ADDR_PORT_DATA come over the same register port
//
// Overview of operation
// RULE1 - general mask at E0h resets zero; bit6 sleep, bit5 gpio, bit0 supply
// RULE2 - general mask bits 4..1 enable analog columns 3..0
// RULE3 - block mask at E1h resets zero; bits enable digital blocks 7..0
// RULE4 - reading vector register E2h gives highest-priority pending vector
// RULE5 - any write to vector register clears every pending flag
// RULE6 - all pin interrupts merge into one source, one priority, one vector
// RULE7 - pin polarity selectable, each pin masked by its enable bit
// RULE8 - pin interrupt needs its pin enable and general mask gpio bit
// RULE9 - trigger types: change since last read, rising edge, falling edge
// RULE10 - change mode captures pin on port read, fires when pin differs
// RULE11 - trigger code 00 gives no interrupt; software picks nonzero code
// RULE12 - software sets drive mode so the pin works as input
// RULE13 - gpio request also needs processor global interrupt enable
// RULE14 - pin outputs are ORed; gpio pending sets on OR rising edge only
// RULE15 - while any pin output stays high no further gpio request arises
// RULE16 - each source has a pending flop held until serviced, reset or write
// RULE17 - pending requests only when its mask and global enable are set
// RULE18 - lowest priority number wins; supply is 1, sleep is 15
// RULE19 - acknowledge with no enabled pending source yields vector zero
// RULE20 - vector byte is 04h plus four per priority step, zero if none
//
// Design decision made here: strobed register access.
`default_nettype none
`include "irq_defines.svh"
module irq_mask_vector_gpio
    import irq_pkg::*;
#(
    parameter int NUM_PINS = 8
) (
    input  wire logic           CLK,
    input  wire logic           RESET,
    input  wire irq_pkg::reg_req_s REG_REQ,
    output logic [7:0]          REG_RDATA,
    input  wire logic           SUPPLY_EVENT,
    input  wire logic           SLEEP_EVENT,
    input  wire logic [7:0]     BLOCK_EVENT,
    input  wire logic [3:0]     COLUMN_EVENT,
    input  wire logic [NUM_PINS-1:0] PIN_IN,
    input  wire logic           GLOBAL_IE,
    input  wire logic           IRQ_ACK,
    output logic                IRQ_REQ,
    output logic [7:0]          IRQ_VECTOR
);
    initial begin
        if (NUM_PINS < 1 || NUM_PINS > 8) begin
            $error("irq_mask_vector_gpio: NUM_PINS must be 1..8");
        end
    end

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [7:0]                general_irq_mask;
    logic [7:0]                block_irq_mask;
    logic [NUM_PINS-1:0]       port_pin_irq_enable;
    logic [NUM_PINS-1:0]       port_edge_select_low;
    logic [NUM_PINS-1:0]       port_edge_select_high;
    logic [`NUM_SOURCES-1:0]   pending;
    logic [`NUM_SOURCES-1:0]   source_enable;
    logic [`NUM_SOURCES-1:0]   source_event;
    logic [`NUM_SOURCES-1:0]   active;
    logic [`NUM_SOURCES-1:0]   ack_clear;
    logic [NUM_PINS-1:0]       pin_irq_out;
    logic                      pins_any;
    logic                      pins_any_prev;
    logic                      gpio_event;
    logic                      port_read;
    logic                      vector_write;
    logic                      pick_valid;
    logic [7:0]                pick_vector;

    function automatic logic hit(input reg_req_s r, input logic [7:0] a);
        return r.addr == a;
    endfunction

    always_comb begin
        port_read    = REG_REQ.rd && hit(REG_REQ, `ADDR_PORT_DATA);
        vector_write = REG_REQ.wr && hit(REG_REQ, `ADDR_IRQ_VECTOR);
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            general_irq_mask <= `RST_BYTE;                     // [RULE1]
        end else if (REG_REQ.wr && hit(REG_REQ, `ADDR_GENERAL_MASK)) begin
            general_irq_mask <= REG_REQ.wdata & `GEN_WRITABLE; // [RULE1] [RULE2]
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            block_irq_mask <= `RST_BYTE;                       // [RULE3]
        end else if (REG_REQ.wr && hit(REG_REQ, `ADDR_BLOCK_MASK)) begin
            block_irq_mask <= REG_REQ.wdata;                   // [RULE3]
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            port_pin_irq_enable   <= '0;
            port_edge_select_low  <= '0;
            port_edge_select_high <= '0;
        end else if (REG_REQ.wr) begin
            if (hit(REG_REQ, `ADDR_PIN_IRQ_ENABLE)) begin
                port_pin_irq_enable <= REG_REQ.wdata[NUM_PINS-1:0]; // [RULE7]
            end else if (hit(REG_REQ, `ADDR_EDGE_SEL_LOW)) begin
                port_edge_select_low <= REG_REQ.wdata[NUM_PINS-1:0];
            end else if (hit(REG_REQ, `ADDR_EDGE_SEL_HIGH)) begin
                port_edge_select_high <= REG_REQ.wdata[NUM_PINS-1:0];
            end
        end
    end

    // ****************************************************************
    // gpio pins
    // ****************************************************************
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        gpio_pin_trigger u_trig (
            .clk     (CLK),
            .reset   (RESET),
            .pin     (PIN_IN[p]),
            .enable  (port_pin_irq_enable[p]),
            .mode    (trig_mode_e'({port_edge_select_high[p],
                                    port_edge_select_low[p]})), // [RULE11]
            .capture (port_read),
            .irq_out (pin_irq_out[p])
        );
    end

    always_comb begin
        pins_any = |pin_irq_out;                               // [RULE6] [RULE14]
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            pins_any_prev <= 1'b0;
        end else begin
            pins_any_prev <= pins_any;
        end
    end

    always_comb begin
        gpio_event = pins_any && !pins_any_prev;               // [RULE14] [RULE15]
    end

    // ****************************************************************
    // pending flops and request
    // ****************************************************************
    always_comb begin
        source_event = {SLEEP_EVENT, gpio_event, COLUMN_EVENT,
                        BLOCK_EVENT, SUPPLY_EVENT};
        source_enable = {general_irq_mask[`GEN_SLEEP_BIT],
                         general_irq_mask[`GEN_GPIO_BIT],      // [RULE8]
                         general_irq_mask[`GEN_COL_MSB:`GEN_COL_LSB], // [RULE2]
                         block_irq_mask,
                         general_irq_mask[`GEN_SUPPLY_BIT]};
        active = pending & source_enable;                      // [RULE17]
    end

    irq_priority_pick #(
        .N (`NUM_SOURCES)
    ) u_pick (
        .req    (active),
        .valid  (pick_valid),
        .vector (pick_vector)
    );

    // one-hot of the slot being serviced on acknowledge
    always_comb begin
        ack_clear = '0;
        for (int s = 0; s < `NUM_SOURCES; s++) begin
            if (IRQ_ACK && pick_valid &&
                pick_vector == 8'(`VEC_BASE + 8'(s) * `VEC_STEP)) begin
                ack_clear[s] = 1'b1;                           // [RULE16]
            end
        end
    end

    // new events win over acknowledge and vector-write clears
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pending <= `RST_SOURCES;                           // [RULE16]
        end else if (vector_write) begin
            pending <= source_event;                           // [RULE5]
        end else begin
            pending <= (pending & ~ack_clear) | source_event;  // [RULE16]
        end
    end

    always_comb begin
        IRQ_REQ = GLOBAL_IE && pick_valid;                     // [RULE13] [RULE17]
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            IRQ_VECTOR <= `VEC_NONE;
        end else if (IRQ_ACK) begin
            IRQ_VECTOR <= pick_vector;                         // [RULE18] [RULE19]
        end
    end

    // ****************************************************************
    // read data, one cycle after the strobe
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (RESET) begin
            REG_RDATA <= `RST_BYTE;
        end else if (REG_REQ.rd) begin
            if (hit(REG_REQ, `ADDR_GENERAL_MASK)) begin
                REG_RDATA <= general_irq_mask;
            end else if (hit(REG_REQ, `ADDR_BLOCK_MASK)) begin
                REG_RDATA <= block_irq_mask;
            end else if (hit(REG_REQ, `ADDR_IRQ_VECTOR)) begin
                REG_RDATA <= pick_vector;                      // [RULE4] [RULE20]
            end else if (hit(REG_REQ, `ADDR_PORT_DATA)) begin
                REG_RDATA <= 8'(PIN_IN);
            end else if (hit(REG_REQ, `ADDR_PIN_IRQ_ENABLE)) begin
                REG_RDATA <= 8'(port_pin_irq_enable);
            end else if (hit(REG_REQ, `ADDR_EDGE_SEL_LOW)) begin
                REG_RDATA <= 8'(port_edge_select_low);
            end else if (hit(REG_REQ, `ADDR_EDGE_SEL_HIGH)) begin
                REG_RDATA <= 8'(port_edge_select_high);
            end else begin
                REG_RDATA <= `RST_BYTE;
            end
        end else begin
            REG_RDATA <= `RST_BYTE;
        end
    end
endmodule // irq_mask_vector_gpio
`default_nettype wire

// [sim/irq_mask_vector_gpio_monitor.sv]
// checker of the interrupt mask, vector and gpio block
// assumes it is bound to the top module and sees its ports only
`default_nettype none
module irq_mask_vector_gpio_monitor #(
    parameter int NUM_PINS = 8
) (
    input wire logic                CLK,
    input wire logic                RESET,
    input var  irq_pkg::reg_req_s   REG_REQ,
    input wire logic [7:0]          REG_RDATA,
    input wire logic                SUPPLY_EVENT,
    input wire logic                SLEEP_EVENT,
    input wire logic [7:0]          BLOCK_EVENT,
    input wire logic [3:0]          COLUMN_EVENT,
    input wire logic [NUM_PINS-1:0] PIN_IN,
    input wire logic                GLOBAL_IE,
    input wire logic                IRQ_ACK,
    input wire logic                IRQ_REQ,
    input wire logic [7:0]          IRQ_VECTOR
);
    timeunit 1ns;
    timeprecision 100ps;
    import irq_pkg::*;
    // ****************************************************************
    // shadow of the mask registers
    // ****************************************************************
    logic [7:0] gen;
    logic [7:0] blk;
    logic       quiet;
    assign quiet = !SUPPLY_EVENT && !SLEEP_EVENT && BLOCK_EVENT == 8'h00 && COLUMN_EVENT == 4'h0;
    always_ff @(posedge CLK) begin
        if (RESET)
            gen <= 8'h00;
        else if (REG_REQ.wr && REG_REQ.addr == 8'he0)
            gen <= REG_REQ.wdata & 8'h7f;
    end
    always_ff @(posedge CLK) begin
        if (RESET)
            blk <= 8'h00;
        else if (REG_REQ.wr && REG_REQ.addr == 8'he1)
            blk <= REG_REQ.wdata;
    end
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking dc @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence s_no_clear;
        !(REG_REQ.wr && REG_REQ.addr inside {8'he0, 8'he2});
    endsequence
    sequence s_supply_set;
        (SUPPLY_EVENT && gen[0]) and s_no_clear;
    endsequence
    sequence s_supply_ack;
        s_supply_set ##1 ((!IRQ_ACK) and s_no_clear) ##1 (IRQ_ACK and s_no_clear);
    endsequence
    AST_IE_GATES: assert property (!GLOBAL_IE |-> !IRQ_REQ)
        else $error("request raised without global enable");
    AST_MASK_GATES: assert property (gen == 8'h00 && blk == 8'h00 |-> !IRQ_REQ)
        else $error("request raised with all masks clear");
    AST_RDATA_IDLE: assert property (!REG_REQ.rd |=> REG_RDATA == 8'h00)
        else $error("read data not zero outside read answer");
    AST_GEN_READ: assert property (REG_REQ.rd && REG_REQ.addr == 8'he0 |=> REG_RDATA == gen)
        else $error("general mask read back wrong");
    AST_BLK_READ: assert property (REG_REQ.rd && REG_REQ.addr == 8'he1 |=> REG_RDATA == blk)
        else $error("block mask read back wrong");
    AST_VEC_WRITE_CLEARS: assert property (REG_REQ.wr && REG_REQ.addr == 8'he2 && !gen[5] && quiet |=> !IRQ_REQ)
        else $error("request survived a vector write");
    AST_EMPTY_ACK: assert property (IRQ_ACK && GLOBAL_IE && !IRQ_REQ |=> IRQ_VECTOR == 8'h00)
        else $error("empty acknowledge gave nonzero vector");
    AST_SUPPLY_FIRST: assert property (s_supply_ack |=> IRQ_VECTOR == 8'h04)
        else $error("supply monitor did not win the acknowledge");
    AST_RESET_CLEARS: assert property (disable iff (1'b0) RESET |=> !IRQ_REQ && IRQ_VECTOR == 8'h00 && REG_RDATA == 8'h00)
        else $error("outputs not cleared by reset");
endmodule // irq_mask_vector_gpio_monitor

bind irq_mask_vector_gpio irq_mask_vector_gpio_monitor #(.NUM_PINS(NUM_PINS)) i_monitor (
    .CLK(CLK), .RESET(RESET), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
    .SUPPLY_EVENT(SUPPLY_EVENT), .SLEEP_EVENT(SLEEP_EVENT), .BLOCK_EVENT(BLOCK_EVENT),
    .COLUMN_EVENT(COLUMN_EVENT), .PIN_IN(PIN_IN), .GLOBAL_IE(GLOBAL_IE),
    .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR)
);
`default_nettype wire

// [sim/cpu_core_model.sv]
// processor core model: global enable flag and acknowledge of requests
// assumes the request is a level and the vector stands after the ack edge
`default_nettype none
module cpu_core_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       irq_req,
    input  wire logic [7:0] irq_vector,
    input  wire logic       sw_ie,
    input  wire logic       take,
    input  wire logic       poke,
    input  wire logic [3:0] lat,
    output logic            global_ie,
    output logic            irq_ack,
    output logic [7:0]      last_vec,
    output logic [7:0]      acks
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // flag, acknowledge after lat waiting cycles, vector capture
    // ****************************************************************
    logic [3:0] cnt;
    logic       ack_d;
    always_ff @(posedge clk) begin
        global_ie <= !reset && sw_ie;
    end
    always_ff @(posedge clk) begin
        if (reset || irq_ack || !(take && irq_req && global_ie))
            cnt <= 4'h0;
        else
            cnt <= cnt + 4'h1;
    end
    always_ff @(posedge clk) begin
        irq_ack <= !reset && !irq_ack && (poke || (take && irq_req && global_ie && cnt == lat));
        ack_d <= !reset && irq_ack;
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            last_vec <= 8'h00;
            acks <= 8'h00;
        end else if (ack_d) begin
            last_vec <= irq_vector;
            acks <= acks + 8'h01;
        end
    end
endmodule // cpu_core_model
`default_nettype wire

// [sim/irq_mask_vector_gpio_bench.sv]
// self-checking bench of the interrupt mask, vector and gpio block
// assumes the core model and the bound checker are compiled alongside
`default_nettype none
module irq_mask_vector_gpio_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import irq_pkg::*;
    typedef struct packed {
        logic [7:0] g;
        logic [7:0] b;
        logic [1:0] sp;
        logic [7:0] be;
        logic [3:0] ce;
        logic [7:0] v;
    } row_s;
    localparam row_s ROWS [9] = '{
        {8'h01, 8'h00, 2'h2, 8'h00, 4'h0, 8'h04}, {8'h40, 8'h00, 2'h1, 8'h00, 4'h0, 8'h3c},
        {8'h02, 8'h00, 2'h0, 8'h00, 4'h1, 8'h28}, {8'h10, 8'h00, 2'h0, 8'h00, 4'h8, 8'h34},
        {8'h00, 8'h01, 2'h0, 8'h01, 4'h0, 8'h08}, {8'h00, 8'hff, 2'h0, 8'h8c, 4'h0, 8'h10},
        {8'hff, 8'hff, 2'h3, 8'hff, 4'hf, 8'h04}, {8'h40, 8'h00, 2'h2, 8'h00, 4'h0, 8'h00},
        {8'h7e, 8'h00, 2'h1, 8'h00, 4'h6, 8'h2c}};
    logic       CLK, RESET, sup, slp, ie, ack, irq, sw_ie, take, poke;
    reg_req_s   req;
    logic [7:0] rdata, bev, vec, last_vec, acks;
    logic [7:0] pin; // pins only ever driven toward the block
    logic [3:0] cev, lat;
    int         error_cnt = 0;
    int         checks_done = 0;
    irq_mask_vector_gpio #(.NUM_PINS(8)) i_dut (
        .CLK(CLK), .RESET(RESET), .REG_REQ(req), .REG_RDATA(rdata), .SUPPLY_EVENT(sup),
        .SLEEP_EVENT(slp), .BLOCK_EVENT(bev), .COLUMN_EVENT(cev), .PIN_IN(pin),
        .GLOBAL_IE(ie), .IRQ_ACK(ack), .IRQ_REQ(irq), .IRQ_VECTOR(vec));
    cpu_core_model i_core (
        .clk(CLK), .reset(RESET), .irq_req(irq), .irq_vector(vec), .sw_ie(sw_ie), .take(take),
        .poke(poke), .lat(lat), .global_ie(ie), .irq_ack(ack), .last_vec(last_vec), .acks(acks));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic stop_test();
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge CLK);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge CLK);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge CLK);
        req <= '0;
        #1 chk(rdata, e);
    endtask
    task automatic pulse(input logic [1:0] sp, input logic [7:0] be, input logic [3:0] ce);
        @(posedge CLK);
        {sup, slp, bev, cev} <= {sp, be, ce};
        @(posedge CLK);
        {sup, slp, bev, cev} <= '0;
    endtask
    task automatic wait_acks(input logic [7:0] n);
        for (int k = 0; k < 60 && acks !== n; k++)
            @(posedge CLK);
        #1 chk(acks, n);
    endtask
    // mask g, pin enable en, trigger code c, pins b then a, vector e
    task automatic gt(input logic [7:0] g, en, input logic [1:0] c, input logic [7:0] b, a, e);
        wr(8'he0, g);
        wr(8'h01, en);
        wr(8'h02, {8{c[0]}});
        wr(8'h03, {8{c[1]}});
        pin <= b;
        repeat (3) @(posedge CLK);
        rd(8'h00, b);
        wr(8'he2, 8'h00);
        pin <= a;
        repeat (4) @(posedge CLK);
        rd(8'he2, e);
    endtask
    // ****************************************************************
    // clock, watchdog and main sequence
    // ****************************************************************
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        error_cnt++;
        stop_test();
    end
    initial begin
        RESET = 1'b1;
        req = '0;
        {sup, slp, sw_ie, take, poke} = 5'h00;
        {bev, cev, pin, lat} = '0;
        repeat (10) @(posedge CLK);
        RESET <= 1'b0;
        rd(8'he0, 8'h00);
        rd(8'he1, 8'h00);
        rd(8'he2, 8'h00);
        rd(8'h55, 8'h00);
        foreach (ROWS[i]) begin
            wr(8'he0, ROWS[i].g);
            wr(8'he1, ROWS[i].b);
            pulse(ROWS[i].sp, ROWS[i].be, ROWS[i].ce);
            rd(8'he2, ROWS[i].v);
            rd(8'he0, ROWS[i].g & 8'h7f);
            rd(8'he1, ROWS[i].b);
            wr(8'he2, 8'h5a);
            rd(8'he2, 8'h00);
        end
        gt(8'h20, 8'hff, 2'h0, 8'h00, 8'hff, 8'h00);
        gt(8'h20, 8'h03, 2'h1, 8'h00, 8'h01, 8'h38);
        wr(8'he2, 8'h00);
        pin <= 8'h03;
        repeat (4) @(posedge CLK);
        rd(8'he2, 8'h00);
        gt(8'h20, 8'hff, 2'h2, 8'hff, 8'hfe, 8'h38);
        gt(8'h20, 8'hff, 2'h3, 8'h00, 8'h04, 8'h38);
        gt(8'h20, 8'hfe, 2'h1, 8'h00, 8'h01, 8'h00);
        gt(8'h00, 8'hff, 2'h1, 8'h00, 8'h01, 8'h00);
        gt(8'h20, 8'hff, 2'h1, 8'h01, 8'h00, 8'h00);
        wr(8'he2, 8'h00);
        wr(8'he0, 8'h01);
        pulse(2'h2, 8'h00, 4'h0);
        #1 chk({7'h00, irq}, 8'h00);
        @(posedge CLK);
        sw_ie <= 1'b1;
        repeat (2) @(posedge CLK);
        #1 chk({7'h00, irq}, 8'h01);
        wr(8'he0, 8'h00);
        @(posedge CLK);
        poke <= 1'b1;
        @(posedge CLK);
        poke <= 1'b0;
        wait_acks(8'h01);
        chk(last_vec, 8'h00);
        // unmask the left-over supply flag so the vector write really drops a request
        wr(8'he0, 8'h01);
        wr(8'he2, 8'h00);
        wr(8'he1, 8'h04);
        take <= 1'b1;
        pulse(2'h2, 8'h04, 4'h0);
        wait_acks(8'h02);
        chk(last_vec, 8'h04);
        wait_acks(8'h03);
        chk(last_vec, 8'h10);
        chk({7'h00, irq}, 8'h00);
        lat <= 4'h4;
        pulse(2'h2, 8'h00, 4'h0);
        wait_acks(8'h04);
        chk(last_vec, 8'h04);
        take <= 1'b0;
        pulse(2'h2, 8'h00, 4'h0);
        RESET <= 1'b1;
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        rd(8'he2, 8'h00);
        rd(8'he0, 8'h00);
        stop_test();
    end
endmodule // irq_mask_vector_gpio_bench
`default_nettype wire
